// File: dv/cfsr_core_properties.sv
// read port, response buffer and service request properties
`timescale 1ns/1ps
`include "cfsr_defines.svh"
module cfsr_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // events and register port
  input wire logic dev_clear_pulse,
  input wire logic [`CFSR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // service request and talk side
  input wire logic srq_out,
  input wire logic resp_valid,
  input wire logic [31:0] resp_data
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence query_s;
    reg_wr && reg_addr == `CFSR_OFF_QUERY;
  endsequence
  sequence talk_s;
    reg_rd && reg_addr == `CFSR_OFF_RESP;
  endsequence
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  unmapped_zero_a: assert property (
    reg_rd && reg_addr > `CFSR_OFF_POLL |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  srq_reset_a: assert property ($past(!rst_b) |-> !srq_out)
    else $error("service request after reset");
  srq_off_a: assert property (
    reg_wr && reg_addr == `CFSR_OFF_SRQ && !reg_wdata[0] |-> ##2 !srq_out)
    else $error("service request while disabled");
  resp_drop_a: assert property (talk_s |=> !resp_valid)
    else $error("response kept after talk");
  resp_wait_a: assert property (query_s |-> ##[2:16] resp_valid)
    else $error("no response to query");
  resp_hold_a: assert property (
    resp_valid && !reg_wr && !dev_clear_pulse
    && !(reg_rd && reg_addr == `CFSR_OFF_RESP) |=> resp_valid)
    else $error("response lost");
  resp_steady_a: assert property (
    resp_valid && !reg_wr ##1 resp_valid |-> $stable(resp_data))
    else $error("response changed");
  clear_pulse_a: assert property (
    dev_clear_pulse |-> ##2 (!srq_out && !resp_valid))
    else $error("device clear ignored");
  clear_cmd_a: assert property (
    reg_wr && reg_addr == `CFSR_OFF_CTRL && reg_wdata[`CFSR_CTRL_CLR_BIT]
    |-> ##2 (!srq_out && !resp_valid))
    else $error("reinit command ignored");
endmodule
bind cfsr_core cfsr_checker chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .dev_clear_pulse(dev_clear_pulse),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .srq_out(srq_out),
  .resp_valid(resp_valid), .resp_data(resp_data)
);

// File: dv/cfsr_ctl_model.sv
// bus controller model driving the status block register port
`timescale 1ns/1ps
module cfsr_ctl_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // mask goes out as a weight total; name lists are parsed upstream
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // released data never looks valid
  endtask
  // read data is taken only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
endmodule

// File: dv/condition_fault_service_request_test.sv
// self-checking bench for the status and service request block
`timescale 1ns/1ps
`include "cfsr_defines.svh"
module condition_fault_service_request_test;
  import cfsr_pkg::*;
  typedef struct packed {logic [3:0] a; logic [15:0] e;} cfsr_row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cond_in = 8'h00;
  logic prog_err_pulse = 1'b0;
  logic dev_clear_pulse = 1'b0;
  logic output_on = 1'b0;
  logic [7:0] prog_err_code = 8'h27;
  logic option_installed = 1'b1;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, srq_out, resp_valid;
  logic [31:0] resp_data;
  int num_errors = 0;
  int checked = 0;
  // power-on values of live, sticky, mask, fault, SRQ, poll and one unmapped offset
  cfsr_row_t rows [7] = '{'{`CFSR_OFF_LIVE, 16'h0000},
    '{`CFSR_OFF_STICKY, 16'h0000}, '{`CFSR_OFF_MASK, 16'h0000},
    '{`CFSR_OFF_FAULT, 16'h0000}, '{`CFSR_OFF_SRQ, 16'h0000},
    '{`CFSR_OFF_POLL, 16'h0002}, '{4'hF, 16'h0000}};
  always #5 ref_clk = ~ref_clk;
  // model, option and date codes are arbitrary
  cfsr_core #(.ROM_DATE(16'h0415), .MODEL_CODE(8'h3C), .OPTION_CODE(8'h64))
  dut (.ref_clk(ref_clk), .rst_b(rst_b), .cond_in(cond_in),
    .prog_err_pulse(prog_err_pulse), .prog_err_code(prog_err_code),
    .dev_clear_pulse(dev_clear_pulse), .output_on(output_on),
    .option_installed(option_installed), .selftest_on_code(8'h0C),
    .selftest_off_code(8'h06), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .srq_out(srq_out), .resp_valid(resp_valid),
    .resp_data(resp_data));
  cfsr_ctl_model p (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // query, wait bounded for the buffer, then talk it out once
  task automatic q(input cfsr_query_t c, input logic [31:0] e);
    int n;
    p.wr(`CFSR_OFF_QUERY, {12'h000, c});
    for (n = 0; n < 40 && resp_valid !== 1'b1; n++)
      @(negedge ref_clk);
    if (n == 40)
    begin
      num_errors++;
      stop_test;
    end
    else
    begin
      // upper half only reaches the talk side, so look while it stands
      cmp(resp_data[31:16], e[31:16]);
      p.rd(`CFSR_OFF_RESP, d);
      cmp(d, e[15:0]);
      cmp({15'h0000, resp_valid}, 16'h0000);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      p.rd(rows[i].a, d);
      cmp(d, rows[i].e);
    end
    p.wr(`CFSR_OFF_MASK, 16'h00A5);
    p.rd(`CFSR_OFF_MASK, d);
    cmp(d, 16'h00A5);
    p.wr(`CFSR_OFF_MASK, 16'h0001);
    p.wr(`CFSR_OFF_SRQ, 16'h0001);
    cond_in <= 8'h01;
    repeat (8) @(negedge ref_clk);
    cmp({15'h0000, srq_out}, 16'h0001);
    p.rd(`CFSR_OFF_FAULT, d);
    cmp(d, 16'h0001);
    p.rd(`CFSR_OFF_FAULT, d);
    cmp(d, 16'h0000);
    repeat (3) @(negedge ref_clk);
    cmp({15'h0000, srq_out}, 16'h0000);
    @(posedge ref_clk);
    cond_in <= 8'h03;
    repeat (8) @(posedge ref_clk);
    cond_in <= 8'h01;
    repeat (8) @(posedge ref_clk);
    p.rd(`CFSR_OFF_STICKY, d);
    cmp(d, 16'h0003);
    p.rd(`CFSR_OFF_STICKY, d);
    cmp(d, 16'h0001);
    p.rd(`CFSR_OFF_FAULT, d);
    cmp(d, 16'h0000);
    @(posedge ref_clk);
    prog_err_pulse <= 1'b1;
    @(posedge ref_clk);
    prog_err_pulse <= 1'b0;
    repeat (6) @(posedge ref_clk);
    p.rd(`CFSR_OFF_LIVE, d);
    cmp(d, 16'h0101);
    p.rd(`CFSR_OFF_ERR, d);
    cmp(d, 16'h0027);
    q(CFSR_Q_LIVE, 32'h0000_0257);
    q(CFSR_Q_MASK, 32'h0000_0FF1);
    q(CFSR_Q_SRQ, 32'h0000_0001);
    q(CFSR_Q_ERR, 32'h0000_0F39);
    q(CFSR_Q_TEST, 32'h0000_0FF6);
    @(posedge ref_clk);
    output_on <= 1'b1;
    q(CFSR_Q_TEST, 32'h0000_0F12);
    q(CFSR_Q_ID, 32'h003C_0064);
    @(posedge ref_clk);
    option_installed <= 1'b0;
    q(CFSR_Q_ID, 32'h003C_0000);
    q(CFSR_Q_ROM, 32'h0000_0415);
    q(CFSR_Q_STICKY, 32'h0000_0257);
    q(CFSR_Q_FAULT, 32'h0000_0FF0);
    // a newer error replaces the stored code
    @(posedge ref_clk);
    prog_err_code <= 8'h05;
    prog_err_pulse <= 1'b1;
    @(posedge ref_clk);
    prog_err_pulse <= 1'b0;
    p.rd(`CFSR_OFF_ERR, d);
    cmp(d, 16'h0005);
    @(posedge ref_clk);
    dev_clear_pulse <= 1'b1;
    @(posedge ref_clk);
    dev_clear_pulse <= 1'b0;
    p.rd(`CFSR_OFF_POLL, d);
    cmp(d, 16'h0000);
    p.wr(`CFSR_OFF_MASK, 16'h0001);
    p.wr(`CFSR_OFF_SRQ, 16'h0000);
    p.wr(`CFSR_OFF_CTRL, 16'h0002);
    p.rd(`CFSR_OFF_SRQ, d);
    cmp(d, 16'h0001);
    p.wr(`CFSR_OFF_CTRL, 16'h0001);
    p.rd(`CFSR_OFF_MASK, d);
    cmp(d, 16'h0000);
    p.rd(`CFSR_OFF_SRQ, d);
    cmp(d, 16'h0000);
    stop_test;
  end
endmodule

// File: src/cfsr_core.sv
// condition, sticky, fault and service request status block
// Operation
// RULE1: live condition register follows present conditions; readable by query.
// RULE2: sticky register catches every bit set live since its last read.
// RULE3: sticky register uses the same bit positions as live register.
// RULE4: enable mask picks which conditions may set fault bits.
// RULE5: enable mask is all zeros after power-on or reinit.
// RULE6: controller writes mask as sum of weights or name list.
// RULE7: name lists are comma separated, any order accepted.
// RULE8: mask query returns the enabled weights as decimal total.
// RULE9: fault bit set only on rising live bit with mask set.
// RULE10: fault bits stay set until fault query read clears them.
// RULE11: service request enable, 0 off 1 on, off after init.
// RULE12: service request setting query answers one digit 0 or 1.
// RULE13: reinit command or device clear restores power-on, clears powerup flag.
// RULE14: programming error sets the live error bit, maskable for service.
// RULE15: error query reports two-digit code of latest programming error.
// RULE16: self-test query runs tests per output state, reports failure code.
// RULE17: identification query returns model string plus output option.
// RULE18: firmware query returns four-digit date code.
// RULE19: numeric responses are three digits, leading zeros as spaces.
// RULE20: query replaces buffer; response sent once when talking, then dropped.
// RULE21: service request while enabled and any fault bit set.
// RULE22: reading the sticky register clears it; the code reloads it with the present live bits instead.
`timescale 1ns/1ps
`include "cfsr_defines.svh"
module cfsr_core
  import cfsr_pkg::*;
#(
  parameter int COND_W = 9,
  parameter logic [15:0] ROM_DATE = 16'h1234, // arbitrary date code
  parameter logic [7:0] MODEL_CODE = 8'h5A, // arbitrary model code
  parameter logic [7:0] OPTION_CODE = 8'h01 // arbitrary option code
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // supply conditions and events
  input wire logic [COND_W-2:0] cond_in,
  input wire logic prog_err_pulse,
  input wire logic [7:0] prog_err_code,
  input wire logic dev_clear_pulse,
  input wire logic output_on,
  input wire logic option_installed,
  input wire logic [7:0] selftest_on_code,
  input wire logic [7:0] selftest_off_code,
  // register port
  input wire logic [`CFSR_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // service request and talk side
  output logic srq_out,
  output logic resp_valid,
  output logic [31:0] resp_data
);
  cfsr_resp_if rsp ();

  logic [COND_W-2:0] cond_s1_r;
  logic [COND_W-2:0] cond_s2_r;
  logic [COND_W-1:0] live_r;
  logic [COND_W-1:0] live_prev_r;
  logic [COND_W-1:0] sticky_r;
  logic [COND_W-1:0] mask_r;
  logic [COND_W-1:0] fault_r;
  logic srq_en_r;
  logic err_live_r;
  logic [7:0] err_code_r;
  logic pon_r;
  logic srq_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic resp_valid_r;
  logic [31:0] resp_data_r;
  logic [31:0] resp_nxt;
  logic fmt_pend_r;
  cfsr_query_t q_r;
  logic [COND_W-1:0] rise;
  logic wr_ctrl;
  logic clr_cmd;
  logic rd_sticky;
  logic rd_fault;
  logic q_wr;
  cfsr_query_t q_sel;
  logic talk_rd;

  cfsr_fmt u_fmt (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .rsp(rsp)
  );

  // decode of the register strobes
  assign wr_ctrl = reg_wr && (reg_addr == `CFSR_OFF_CTRL);
  assign clr_cmd = dev_clear_pulse ||
    (wr_ctrl && reg_wdata[`CFSR_CTRL_CLR_BIT]); // RULE13
  assign q_wr = reg_wr && (reg_addr == `CFSR_OFF_QUERY);
  assign q_sel = cfsr_query_t'(reg_wdata[3:0]);
  assign rd_sticky = (reg_rd && reg_addr == `CFSR_OFF_STICKY) ||
    (q_wr && q_sel == CFSR_Q_STICKY);
  assign rd_fault = (reg_rd && reg_addr == `CFSR_OFF_FAULT) ||
    (q_wr && q_sel == CFSR_Q_FAULT);
  assign talk_rd = reg_rd && (reg_addr == `CFSR_OFF_RESP);

  // conditions come from pins, so two flops before use
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cond_s1_r <= '0;
      cond_s2_r <= '0;
    end
    else
    begin
      cond_s1_r <= cond_in;
      cond_s2_r <= cond_s1_r;
    end
  end

  // error level holds until reinit; latest code kept
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
    begin
      err_live_r <= 1'b0;
      err_code_r <= 8'h00;
    end
    else if (prog_err_pulse)
    begin
      err_live_r <= 1'b1; // RULE14
      err_code_r <= prog_err_code; // RULE15
    end
  end

  // live register; error bit sits on top of the pin conditions
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
    begin
      live_r <= '0;
      live_prev_r <= '0;
    end
    else
    begin
      live_r <= {err_live_r, cond_s2_r}; // RULE1
      live_prev_r <= live_r;
    end
  end

  assign rise = live_r & ~live_prev_r;

  // sticky copy; a new set wins over the read clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
      sticky_r <= '0;
    else if (rd_sticky)
      sticky_r <= live_r; // RULE22 RULE2
    else
      sticky_r <= sticky_r | live_r; // RULE2 RULE3
  end

  // enable mask, written as a weight total
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
      mask_r <= COND_W'(`CFSR_MASK_RESET); // RULE5
    else if (reg_wr && reg_addr == `CFSR_OFF_MASK)
      mask_r <= reg_wdata[COND_W-1:0]; // RULE4 RULE6 RULE7
  end

  // faults latch on edges only; edge in read cycle survives
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
      fault_r <= '0;
    else if (rd_fault)
      fault_r <= rise & mask_r; // RULE10
    else
      fault_r <= fault_r | (rise & mask_r); // RULE9 RULE4
  end

  // service request enable
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
      srq_en_r <= `CFSR_SRQ_RESET; // RULE11
    else if (reg_wr && reg_addr == `CFSR_OFF_SRQ)
      srq_en_r <= reg_wdata[0]; // RULE11
    else if (wr_ctrl)
      srq_en_r <= reg_wdata[`CFSR_CTRL_SRQ_BIT];
  end

  // service request output, one cycle behind the fault bits
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      srq_r <= 1'b0;
    else
      srq_r <= srq_en_r && (|fault_r); // RULE21
  end

  // powerup flag: set from reset, cleared by reinit
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      pon_r <= 1'b1;
    else if (clr_cmd)
      pon_r <= 1'b0; // RULE13
  end

  // register reads, data in the following cycle
  always_comb
  begin
    rdata_nxt = 16'h0000;
    unique case (reg_addr)
      `CFSR_OFF_LIVE: rdata_nxt = 16'(live_r); // RULE1
      `CFSR_OFF_STICKY: rdata_nxt = 16'(sticky_r);
      `CFSR_OFF_MASK: rdata_nxt = 16'(mask_r); // RULE8
      `CFSR_OFF_FAULT: rdata_nxt = 16'(fault_r);
      `CFSR_OFF_SRQ: rdata_nxt = {15'h0000, srq_en_r}; // RULE12
      `CFSR_OFF_ERR: rdata_nxt = {8'h00, err_code_r};
      `CFSR_OFF_POLL:
      begin
        rdata_nxt[`CFSR_POLL_PON_BIT] = pon_r;
        rdata_nxt[`CFSR_POLL_ERR_BIT] = err_live_r;
        rdata_nxt[`CFSR_POLL_RQS_BIT] = srq_r;
      end
      `CFSR_OFF_RESP: rdata_nxt = resp_data_r[15:0];
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      rdata_r <= 16'h0000;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 16'h0000;
  end

  // query capture: snapshot value and start the decimal converter
  assign rsp.load = q_wr && !clr_cmd;
  assign rsp.query = q_sel;
  assign rsp.digits = 4'h3;
  always_comb
  begin
    rsp.value = 10'h000;
    unique case (q_sel)
      CFSR_Q_LIVE: rsp.value = 10'(live_r);
      CFSR_Q_STICKY: rsp.value = 10'(sticky_r);
      CFSR_Q_MASK: rsp.value = 10'(mask_r); // RULE8
      CFSR_Q_FAULT: rsp.value = 10'(fault_r);
      CFSR_Q_ERR: rsp.value = {2'b00, err_code_r}; // RULE15
      CFSR_Q_TEST: rsp.value = {2'b00, output_on ? selftest_on_code :
        selftest_off_code}; // RULE16
      default: rsp.value = 10'h000;
    endcase
  end

  // leading zeros shown as space (0xF nibble) for the talk side
  always_comb
  begin
    resp_nxt = 32'h0000_0000;
    unique case (q_r)
      CFSR_Q_SRQ: resp_nxt = {28'h0000000, 3'b000, srq_en_r}; // RULE12
      CFSR_Q_ID: resp_nxt = {8'h00, MODEL_CODE, 8'h00,
        option_installed ? OPTION_CODE : 8'h00}; // RULE17
      CFSR_Q_ROM: resp_nxt = {16'h0000, ROM_DATE}; // RULE18
      default:
      begin
        resp_nxt[11:0] = rsp.bcd; // RULE19
        if (rsp.bcd[11:8] == 4'h0)
        begin
          resp_nxt[11:8] = 4'hF; // RULE19
          if (rsp.bcd[7:4] == 4'h0)
            resp_nxt[7:4] = 4'hF;
        end
      end
    endcase
  end

  // one-deep output buffer: newest query replaces, talk read drops it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || clr_cmd)
    begin
      q_r <= CFSR_Q_LIVE;
      fmt_pend_r <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_data_r <= 32'h0000_0000;
    end
    else if (q_wr)
    begin
      q_r <= q_sel;
      fmt_pend_r <= 1'b1;
      resp_valid_r <= 1'b0; // RULE20
    end
    else if (fmt_pend_r && !rsp.busy)
    begin
      fmt_pend_r <= 1'b0;
      resp_valid_r <= 1'b1;
      resp_data_r <= resp_nxt;
    end
    else if (talk_rd && resp_valid_r)
    begin
      resp_valid_r <= 1'b0; // RULE20
      resp_data_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;
  assign srq_out = srq_r;
  assign resp_valid = resp_valid_r;
  assign resp_data = resp_data_r;
endmodule

// File: src/cfsr_defines.svh
// offsets, field positions, reset values and codes for the status block
`ifndef CFSR_DEFINES_SVH
`define CFSR_DEFINES_SVH
`define CFSR_ADDR_W 4
`define CFSR_OFF_LIVE 4'h0
`define CFSR_OFF_STICKY 4'h1
`define CFSR_OFF_MASK 4'h2
`define CFSR_OFF_FAULT 4'h3
`define CFSR_OFF_SRQ 4'h4
`define CFSR_OFF_ERR 4'h5
`define CFSR_OFF_TEST 4'h6
`define CFSR_OFF_ID 4'h7
`define CFSR_OFF_ROM 4'h8
`define CFSR_OFF_CTRL 4'h9
`define CFSR_OFF_RESP 4'hA
`define CFSR_OFF_QUERY 4'hB
`define CFSR_OFF_POLL 4'hC
`define CFSR_CTRL_CLR_BIT 0
`define CFSR_CTRL_SRQ_BIT 1
`define CFSR_MASK_RESET 9'h000
`define CFSR_SRQ_RESET 1'b0
`define CFSR_ERR_BIT 8
`define CFSR_POLL_PON_BIT 1
`define CFSR_POLL_RQS_BIT 6
`define CFSR_POLL_ERR_BIT 5
`define CFSR_TEST_PASS 8'h00
`endif

// File: src/cfsr_fmt.sv
// binary to three-digit decimal converter for query responses
`timescale 1ns/1ps
module cfsr_fmt
  import cfsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // core side
  cfsr_resp_if.fmt rsp
);
  logic [9:0] rem_r;
  logic [3:0] hund_r;
  logic [3:0] tens_r;
  logic busy_r;

  // repeated subtraction; a few cycles, traded for no divider
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rem_r <= 10'h000;
      hund_r <= 4'h0;
      tens_r <= 4'h0;
      busy_r <= 1'b0;
    end
    else if (rsp.load)
    begin
      rem_r <= rsp.value;
      hund_r <= 4'h0;
      tens_r <= 4'h0;
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      if (rem_r >= 10'h064)
      begin
        rem_r <= rem_r - 10'h064;
        hund_r <= hund_r + 4'h1;
      end
      else if (rem_r >= 10'h00A)
      begin
        rem_r <= rem_r - 10'h00A;
        tens_r <= tens_r + 4'h1;
      end
      else
        busy_r <= 1'b0;
    end
  end

  assign rsp.bcd = {hund_r, tens_r, rem_r[3:0]};
  assign rsp.busy = busy_r | rsp.load;
endmodule

// File: src/cfsr_pkg.sv
// types shared by the status block and its response formatter
package cfsr_pkg;
  typedef enum logic [3:0] {
    CFSR_Q_LIVE,
    CFSR_Q_STICKY,
    CFSR_Q_MASK,
    CFSR_Q_FAULT,
    CFSR_Q_SRQ,
    CFSR_Q_ERR,
    CFSR_Q_TEST,
    CFSR_Q_ID,
    CFSR_Q_ROM
  } cfsr_query_t;
endpackage

// File: src/cfsr_resp_if.sv
// carrier between the status core and its response formatter
`timescale 1ns/1ps
interface cfsr_resp_if;
  import cfsr_pkg::*;
  logic load;
  cfsr_query_t query;
  logic [9:0] value;
  logic [3:0] digits;
  logic [11:0] bcd;
  logic busy;
  modport core (output load, output query, output value, output digits,
    input bcd, input busy);
  modport fmt (input load, input query, input value, input digits,
    output bcd, output busy);
endinterface
